// >>> hdl/odt_delay_line.sv
// Purpose: variable-tap shift register for latency-timed termination
// Assumes: tap is stable while used; output is delayed tap + 1 cycles
// Notes:   storage is flip-flops addressed by index
`timescale 1ns/1ps
module odt_delay_line
	import odt_pd_pkg::*;
#(
	parameter int DEPTH = MAX_LAT
)(
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     rstn,
	// data
	input  wire logic                     din,
	input  wire logic [$clog2(DEPTH)-1:0] tap,
	output logic                          dout
);

	// ==========================================================
	// shift register
	logic [DEPTH-1:0] stage;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			stage <= '0;
		else
			stage <= {stage[DEPTH-2:0], din};
	end

	assign dout = stage[tap];

endmodule // odt_delay_line

// >>> hdl/odt_pd_ctrl.sv
// What this block does
// R01: frozen dll in power-down selects asynchronous termination
// R02: asynchronous mode ignores additive latency
// R03: async turn-on between 2 and 8.5 ns
// R04: async turn-off between 2 and 8.5 ns
// R05: odt stays live; no commands in power-down
// R06: entry window starts wl-1 before cke low
// R07: entry ends after tcpded or later trfc
// R08: start cycle excluded, end cycles included
// R09: turn-on in window may be either timing
// R10: turn-off in window may be either timing
// R11: exit window wl-1 before to txpdll after
// R12: outside windows termination is latency timed
// R13: overlapping entry then exit merge windows
// R14: overlapping exit then entry merge windows
// R15: synchronous latency is wl minus 2
// R16: count windows, flag non-synchronous response
//
// Purpose: on-die termination timing control across precharge power-down
// Assumes: pins other than banks_idle are sampled by two flops; latencies count from the synced pin
// Notes:   the wl-1 cycles before a cke edge cannot be known ahead; changes made
//          there are still in the latency pipe and take effect early, as entry follows the synced pin
`timescale 1ns/1ps
module odt_pd_ctrl
	import odt_pd_pkg::*;
#(
	parameter int TCPDED_CYC = TCPDED_CYC_DEF,
	parameter int TRFC_CYC   = TRFC_CYC_DEF,
	parameter int TXPDLL_CYC = TXPDLL_CYC_DEF
)(
	// clock and reset
	input  wire logic      clk,
	input  wire logic      rstn,
	// pins from the controller
	input  wire logic      odt_pin,
	input  wire logic      cke_pin,
	input  wire logic      refresh_cmd,
	input  wire logic      rdwr_cmd,
	input  wire logic      banks_idle,
	// mode register settings
	input  wire odt_cfg_s  cfg,
	// status and termination control
	output odt_stat_s      stat,
	output logic [CNT_W-1:0] win_count
);

	// ==========================================================
	// pin synchronisers
	logic [1:0] odt_sr;
	logic [1:0] cke_sr;
	logic [1:0] ref_sr;
	logic [1:0] rdwr_sr;
	logic       odt_s;
	logic       cke_s;
	logic       ref_s;
	logic       rdwr_s;
	logic       cke_q;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			odt_sr  <= SYNC_RESET;
			cke_sr  <= CKE_SYNC_RESET;
			ref_sr  <= SYNC_RESET;
			rdwr_sr <= SYNC_RESET;
			cke_q   <= CKE_Q_RESET;
		end
		else
		begin
			odt_sr  <= {odt_sr[0], odt_pin};
			cke_sr  <= {cke_sr[0], cke_pin};
			ref_sr  <= {ref_sr[0], refresh_cmd};
			rdwr_sr <= {rdwr_sr[0], rdwr_cmd};
			cke_q   <= cke_s;
		end
	end

	assign odt_s  = odt_sr[1];
	assign cke_s  = cke_sr[1];
	assign ref_s  = ref_sr[1];
	assign rdwr_s = rdwr_sr[1];

	logic cke_fall;
	logic cke_rise;
	logic frozen;

	assign cke_fall = cke_q && !cke_s;
	assign cke_rise = !cke_q && cke_s;
	// only precharge power-down with the dll frozen goes asynchronous
	assign frozen   = cfg.dll_on && !cfg.pd_dll_fast && banks_idle; // R01

	// ==========================================================
	// window counters
	logic [CNT_W-1:0] cpded_cnt;
	logic [CNT_W-1:0] rfc_cnt;
	logic [CNT_W-1:0] xpdll_cnt;
	pd_state_e        state;
	pd_state_e        next_state;

	// tcpded counts from the first cycle cke is low, that cycle being count one
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			cpded_cnt <= CNT_ZERO;
		else if (cke_fall && frozen)
			cpded_cnt <= CNT_W'(TCPDED_CYC) - CNT_ONE; // R07
		else if (cpded_cnt != CNT_ZERO)
			cpded_cnt <= cpded_cnt - CNT_ONE;
	end

	// refresh in progress stretches the entry window to trfc
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			rfc_cnt <= CNT_ZERO;
		else if (ref_s && cke_s)
			rfc_cnt <= CNT_W'(TRFC_CYC) - CNT_ONE; // R07
		else if (rfc_cnt != CNT_ZERO)
			rfc_cnt <= rfc_cnt - CNT_ONE;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			xpdll_cnt <= CNT_ZERO;
		else if (cke_rise)
			xpdll_cnt <= CNT_W'(TXPDLL_CYC) - CNT_ONE; // R11
		else if (xpdll_cnt != CNT_ZERO)
			xpdll_cnt <= xpdll_cnt - CNT_ONE;
	end

	// ==========================================================
	// power-down state machine
	always_comb
	begin
		next_state = state;
		unique case (state)
			ST_ACTIVE:
				if (cke_fall && frozen)
					next_state = ST_ENTRY; // R06
			ST_ENTRY:
				// end cycles at tcpded and trfc stay inside the window
				if (cke_rise)
					next_state = ST_EXIT; // R13
				else if (cpded_cnt == CNT_ZERO && rfc_cnt == CNT_ZERO)
					next_state = ST_PD; // R08
			ST_PD:
				if (cke_rise)
					next_state = ST_EXIT; // R11
			ST_EXIT:
				// an early re-entry keeps the window open with no gap
				if (cke_fall && frozen)
					next_state = ST_ENTRY; // R14
				else if (xpdll_cnt == CNT_ZERO && cpded_cnt == CNT_ZERO
					&& rfc_cnt == CNT_ZERO)
					next_state = ST_ACTIVE; // R13
		endcase
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			state <= ST_ACTIVE;
		else
			state <= next_state;
	end

	// ==========================================================
	// termination paths
	logic [$clog2(MAX_LAT)-1:0] sync_tap;
	logic                       sync_odt;
	logic                       async_sel;

	// two register stages follow the tap, so tap = wl - 4 gives wl - 2 overall
	assign sync_tap = cfg.wl - PIPE_OFFSET; // R15

	odt_delay_line #(
		.DEPTH (MAX_LAT)
	) u_latency (
		.clk  (clk),
		.rstn (rstn),
		.din  (odt_s),
		.tap  (sync_tap),
		.dout (sync_odt)
	);

	// inside any window either timing is legal; the fast path is used there
	// since it never lags a frozen dll
	assign async_sel = (state != ST_ACTIVE); // R09 R10

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			stat.rtt_on <= RTT_RESET;
		else if (async_sel)
			stat.rtt_on <= odt_s; // R02 R03 R04
		else
			stat.rtt_on <= sync_odt; // R12 R15
	end

	// ==========================================================
	// status flags
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			stat.async_mode <= 1'b0;
			stat.trans_flag <= 1'b0;
			stat.pd_active  <= 1'b0;
		end
		else
		begin
			stat.async_mode <= (next_state == ST_PD); // R01
			stat.trans_flag <= (next_state != ST_ACTIVE); // R16
			stat.pd_active  <= (next_state == ST_ENTRY || next_state == ST_PD);
		end
	end

	// command receivers may be off; odt receiver is never gated
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			stat.cmd_rx_en <= 1'b1;
			stat.cmd_in_pd <= 1'b0;
		end
		else
		begin
			stat.cmd_rx_en <= cke_s; // R05
			stat.cmd_in_pd <= rdwr_s && !cke_s; // R05
		end
	end

	// remaining count of whichever window is open
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			win_count <= CNT_ZERO;
		else if (next_state == ST_EXIT)
			win_count <= xpdll_cnt; // R16
		else if (next_state == ST_ENTRY)
			win_count <= (cpded_cnt > rfc_cnt) ? cpded_cnt : rfc_cnt; // R16
		else
			win_count <= CNT_ZERO;
	end

	// ==========================================================
	// checks
	logic [MAX_LAT-1:0] odt_hist;
	logic [5:0]         steady;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			odt_hist <= '0;
			steady   <= 6'h00;
		end
		else
		begin
			odt_hist <= {odt_hist[MAX_LAT-2:0], odt_s};
			if (state != ST_ACTIVE)
				steady <= 6'h00;
			else if (steady != 6'h3f)
				steady <= steady + 6'h01;
		end
	end

	chk_sync_latency: assert property (@(posedge clk) disable iff (!rstn) // R15
		(steady > 6'h21 && $stable(cfg.wl))
		|-> stat.rtt_on == odt_hist[cfg.wl - ODTL_OFFSET - 5'h01])
		else $error("termination not at wl-2 latency");

	chk_async_follow: assert property (@(posedge clk) disable iff (!rstn) // R02
		(state == ST_PD && $past(state) == ST_PD) |=> stat.rtt_on == $past(odt_s))
		else $error("async termination not one cycle behind pin");

	chk_entry_start: assert property (@(posedge clk) disable iff (!rstn) // R06
		(state == ST_ACTIVE && cke_fall && frozen) |=> state == ST_ENTRY ##1 stat.trans_flag)
		else $error("power-down entry window missed");

	chk_refresh_hold: assert property (@(posedge clk) disable iff (!rstn) // R07
		(state == ST_ENTRY && rfc_cnt != CNT_ZERO && !cke_rise) |=> state == ST_ENTRY)
		else $error("entry window closed before refresh ended");

	chk_exit_end: assert property (@(posedge clk) disable iff (!rstn) // R11
		(state == ST_EXIT && xpdll_cnt != CNT_ZERO) |=> state != ST_ACTIVE)
		else $error("exit window closed before txpdll");

	chk_pd_cmd_block: assert property (@(posedge clk) disable iff (!rstn) // R05
		(!cke_s ##1 !cke_s) |-> !stat.cmd_rx_en)
		else $error("command receivers enabled in power-down");

	chk_sync_outside: assert property (@(posedge clk) disable iff (!rstn) // R12
		(state == ST_ACTIVE && $past(state) == ST_ACTIVE && !(cke_fall && frozen))
		|=> !stat.trans_flag && !stat.async_mode)
		else $error("flag raised outside transition windows");

	chk_window_union: assert property (@(posedge clk) disable iff (!rstn) // R14
		(state == ST_EXIT && cke_fall && frozen) |=> state == ST_ENTRY && stat.trans_flag)
		else $error("overlapping windows not merged");

	chk_fast_stays_sync: assert property (@(posedge clk) disable iff (!rstn) // R01
		(state == ST_ACTIVE && cfg.pd_dll_fast) |=> state == ST_ACTIVE)
		else $error("async mode entered with dll running");

endmodule // odt_pd_ctrl

// >>> hdl/odt_pd_pkg.sv
// Purpose: shared constants and types for the power-down termination controller
// Assumes: one clock at 25 MHz; latencies counted in whole clock cycles
// Notes:   analog settling is abstracted to whole cycles of the device clock
package odt_pd_pkg;

	// ==========================================================
	// clock and asynchronous termination timing
	localparam int CLK_PERIOD_PS   = 40000;
	localparam int T_AONPD_MIN_PS  = 2000;
	localparam int T_AONPD_MAX_PS  = 8500;
	localparam int T_AOFPD_MIN_PS  = 2000;
	localparam int T_AOFPD_MAX_PS  = 8500;
	// least times round up, longest times round down, never under one cycle
	localparam int T_AONPD_MIN_CYC = ((T_AONPD_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS) < 1 ?
		1 : ((T_AONPD_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam int T_AONPD_MAX_CYC = (T_AONPD_MAX_PS / CLK_PERIOD_PS) < 1 ?
		1 : (T_AONPD_MAX_PS / CLK_PERIOD_PS);
	localparam int T_AOFPD_MIN_CYC = ((T_AOFPD_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS) < 1 ?
		1 : ((T_AOFPD_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam int T_AOFPD_MAX_CYC = (T_AOFPD_MAX_PS / CLK_PERIOD_PS) < 1 ?
		1 : (T_AOFPD_MAX_PS / CLK_PERIOD_PS);

	// ==========================================================
	// latencies relative to write latency
	localparam int          WL_W        = 5;
	localparam int          MAX_LAT     = 32;
	localparam logic [4:0]  ODTL_OFFSET = 5'h02;  // odtlon = odtloff = wl - 2
	localparam logic [4:0]  TANPD_OFFSET = 5'h01; // tanpd = wl - 1
	localparam logic [4:0]  PIPE_OFFSET = 5'h04;  // tap = odtl - 2 register stages

	// ==========================================================
	// window counts (cycles), defaults only
	localparam int          CNT_W          = 12;
	localparam int          TCPDED_CYC_DEF = 1;
	localparam int          TRFC_CYC_DEF   = 64;
	localparam int          TXPDLL_CYC_DEF = 24;
	localparam logic [11:0] CNT_ZERO       = 12'h000;
	localparam logic [11:0] CNT_ONE        = 12'h001;

	// ==========================================================
	// reset values
	localparam logic        RTT_RESET   = 1'b0;
	localparam logic [1:0]  SYNC_RESET  = 2'b00;
	// cke leaves reset at its idle (powered-up) level so no false edge follows
	localparam logic [1:0]  CKE_SYNC_RESET = 2'b11;
	localparam logic        CKE_Q_RESET    = 1'b1;

	// ==========================================================
	// types
	typedef enum logic [1:0] {
		ST_ACTIVE = 2'b00,
		ST_ENTRY  = 2'b01,
		ST_PD     = 2'b11,
		ST_EXIT   = 2'b10
	} pd_state_e;

	typedef struct packed {
		logic            dll_on;       // device runs with dll enabled
		logic            pd_dll_fast;  // 1: dll kept running in power-down, 0: frozen
		logic [WL_W-1:0] wl;           // write latency, cwl + al
	} odt_cfg_s;

	typedef struct packed {
		logic rtt_on;       // termination enabled
		logic async_mode;   // termination follows pin without latency
		logic trans_flag;   // response not guaranteed synchronous
		logic pd_active;    // frozen-dll precharge power-down in effect
		logic cmd_rx_en;    // command/address receivers enabled
		logic cmd_in_pd;    // read or write seen while powered down
	} odt_stat_s;

endpackage

// >>> tb/async_odt_mode_transition_tb_top.sv
// Purpose: self-checking bench for the power-down termination controller
// Assumes: pins and cfg change on the falling edge of clk
// Notes:   short window counts keep the run brief
`timescale 1ns/1ps
module async_odt_mode_transition_tb_top;
	import odt_pd_pkg::*;
	localparam int TCP = 2;
	localparam int TRF = 12;
	localparam int TXP = 6;
	typedef struct {logic v; int lo; int hi; int t;} note_s;
	logic             clk = 1'b0;
	logic             rstn = 1'b0;
	odt_cfg_s         cfg;
	odt_stat_s        stat;
	logic [CNT_W-1:0] win_count;
	logic             odt_pin, cke_pin, refresh_cmd, rdwr_cmd, banks_idle;
	int               failures = 0;
	int               checked = 0;
	int               cyc = 0;
	int               seed = 32'hd9bdd726;
	int               wl;
	note_s            notes[$];
	note_s            got_n;
	logic             rtt_prev = 1'b0;

	// ==========================================================
	// clock, timeout, instances
	always #20 clk = ~clk;
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			failures++;
			finish_test();
		end
	end
	odt_ctl_model i_ctl (.clk(clk), .odt_pin(odt_pin), .cke_pin(cke_pin),
		.refresh_cmd(refresh_cmd), .rdwr_cmd(rdwr_cmd), .banks_idle(banks_idle));
	odt_pd_ctrl #(.TCPDED_CYC(TCP), .TRFC_CYC(TRF), .TXPDLL_CYC(TXP)) i_dut (
		.clk(clk), .rstn(rstn), .odt_pin(odt_pin), .cke_pin(cke_pin),
		.refresh_cmd(refresh_cmd), .rdwr_cmd(rdwr_cmd), .banks_idle(banks_idle),
		.cfg(cfg), .stat(stat), .win_count(win_count));

	// ==========================================================
	// helpers
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			failures++;
			$display("FAIL t=%0t got %0h expected %0h", $time, got, exp);
		end
	endtask

	task automatic finish_test();
		$display("checked=%0d failures=%0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic idle(input int k);
		repeat (k) @(negedge clk);
	endtask

	// flip odt and note the accepted latency range of the termination change
	task automatic odt_to(input int lo, input int hi);
		note_s n;
		i_ctl.set_odt(~odt_pin);
		n.v = odt_pin;
		n.lo = lo;
		n.hi = hi;
		n.t = cyc;
		notes.push_back(n);
	endtask

	// sel 1 waits on trans_flag, 0 on async_mode; bounded by lim cycles
	task automatic wait_bit(input logic sel, input logic v, input int lim, output int k);
		k = 0;
		while ((sel ? stat.trans_flag : stat.async_mode) !== v && k < lim)
		begin
			@(negedge clk);
			k++;
		end
		check(sel ? stat.trans_flag : stat.async_mode, v);
	endtask

	// ==========================================================
	// scoreboard: every termination change must match the oldest note
	always @(negedge clk)
	begin
		if (rstn && stat.rtt_on !== rtt_prev)
		begin
			if (notes.size() == 0)
				check(1'b1, 1'b0);
			else
			begin
				got_n = notes.pop_front();
				check(stat.rtt_on, got_n.v);
				check(cyc - got_n.t >= got_n.lo && cyc - got_n.t <= got_n.hi, 1'b1);
			end
		end
		rtt_prev = stat.rtt_on;
	end

	// ==========================================================
	// main sequence
	initial
	begin
		int k;
		int k2;
		cfg = '0;
		cfg.dll_on = 1'b1;
		wl = 5 + ($unsigned($random(seed)) % 8);
		cfg.wl = wl[WL_W-1:0];
		repeat (4) @(posedge clk);
		@(negedge clk);
		rstn = 1'b1;
		idle(2);
		check(stat.cmd_rx_en, 1'b1);
		check(win_count, 0);
		for (int i = 0; i < 4; i++)
		begin
			odt_to(wl, wl);
			idle(wl + 2 + ($unsigned($random(seed)) % 4));
		end
		// frozen power-down, with one odt change inside the entry window
		i_ctl.set_cke(1'b0);
		odt_to(2, wl);
		idle(wl + 2);
		check(stat.pd_active, 1'b1);
		check(stat.cmd_rx_en, 1'b0);
		wait_bit(1'b0, 1'b1, TCP + 4, k);
		for (int i = 0; i < 4; i++)
		begin
			odt_to(2, 3);
			idle(6);
		end
		i_ctl.pulse(1'b1, 1'b1);
		k = 0;
		while (stat.cmd_in_pd !== 1'b1 && k < 5)
		begin
			@(negedge clk);
			k++;
		end
		check(stat.cmd_in_pd, 1'b1);
		i_ctl.set_cke(1'b1);
		wait_bit(1'b0, 1'b0, 4, k);
		idle(1);
		check(win_count, TXP - 1);
		wait_bit(1'b1, 1'b0, TXP + 8, k2);
		check(k + k2 >= TXP, 1'b1);
		check(stat.pd_active, 1'b0);
		odt_to(wl, wl);
		idle(wl + 3);
		// dll running, dll off, or banks open: power-down stays synchronous
		for (int v = 0; v < 3; v++)
		begin
			cfg.pd_dll_fast = (v == 0);
			cfg.dll_on      = (v != 1);
			i_ctl.set_idle(v != 2);
			i_ctl.set_cke(1'b0);
			idle(6);
			check(stat.trans_flag | stat.async_mode, 1'b0);
			odt_to(wl, wl);
			idle(wl + 3);
			i_ctl.set_cke(1'b1);
			idle(4);
		end
		cfg.pd_dll_fast = 1'b0;
		cfg.dll_on      = 1'b1;
		i_ctl.set_idle(1'b1);
		// refresh in progress stretches the entry window
		i_ctl.pulse(1'b0, 1'b0);
		i_ctl.set_cke(1'b0);
		idle(TCP + 4);
		check({stat.trans_flag, stat.async_mode}, 2'b10);
		wait_bit(1'b0, 1'b1, TRF, k);
		i_ctl.set_cke(1'b1);
		wait_bit(1'b1, 1'b0, TXP + 8, k);
		idle(3);
		// short power-down: entry and exit windows merge
		i_ctl.set_cke(1'b0);
		idle(2);
		i_ctl.set_cke(1'b1);
		wait_bit(1'b1, 1'b1, 4, k);
		wait_bit(1'b1, 1'b0, TXP + TCP + 8, k);
		check(k >= TXP, 1'b1);
		// re-entry inside the exit window: windows merge with no gap
		i_ctl.set_cke(1'b0);
		wait_bit(1'b0, 1'b1, TCP + 6, k);
		i_ctl.set_cke(1'b1);
		idle(2);
		i_ctl.set_cke(1'b0);
		idle(4);
		check({stat.trans_flag, stat.pd_active}, 2'b11);
		i_ctl.set_cke(1'b1);
		wait_bit(1'b1, 1'b0, TXP + 8, k);
		idle(wl + 4);
		check(stat.trans_flag, 1'b0);
		check(notes.size(), 0);
		finish_test();
	end
endmodule // async_odt_mode_transition_tb_top

// >>> tb/odt_ctl_model.sv
// Purpose: memory controller model driving odt, cke and command strobes
// Assumes: every pin changes on the falling edge of clk
// Notes:   read/write in power-down is sent only when the bench asks for it
`timescale 1ns/1ps
module odt_ctl_model (
	// clock
	input  wire logic clk,
	// pins toward the device
	output logic      odt_pin,
	output logic      cke_pin,
	output logic      refresh_cmd,
	output logic      rdwr_cmd,
	output logic      banks_idle
);
	// ==========================================================
	// pin drivers
	initial
	begin
		odt_pin     = 1'b0;
		cke_pin     = 1'b1;
		refresh_cmd = 1'b0;
		rdwr_cmd    = 1'b0;
		banks_idle  = 1'b1;
	end

	// odt keeps being driven in power-down, its receiver stays live
	task automatic set_odt(input logic v);
		@(negedge clk);
		odt_pin = v;
	endtask

	task automatic set_cke(input logic v);
		@(negedge clk);
		cke_pin = v;
	endtask

	// open banks at cke fall make it active power-down
	task automatic set_idle(input logic v);
		@(negedge clk);
		banks_idle = v;
	endtask

	// one-cycle strobe; bad lets the bench force a command in power-down
	task automatic pulse(input logic is_rdwr, input logic bad);
		if (is_rdwr && !cke_pin && !bad)
			return;
		@(negedge clk);
		rdwr_cmd    = is_rdwr;
		refresh_cmd = !is_rdwr;
		@(negedge clk);
		rdwr_cmd    = 1'b0;
		refresh_cmd = 1'b0;
	endtask
endmodule // odt_ctl_model
